// ### pfh_pkg.sv
// package of constants and types for the parallel flash host controller
package pfh_pkg;
	localparam int PFH_ADDR_W = 25;
	localparam int PFH_DATA_W = 16;
	localparam int PFH_CLK_NS = 25;
	// flash timing in ns, turned into cycles (least times round up)
	localparam int PFH_RANDOM_ACCESS_NS = 110;
	localparam int PFH_PAGE_ACCESS_NS = 25;
	localparam int PFH_RESET_PULSE_NS = 500;
	localparam int PFH_WRITE_PULSE_NS = 35;
	localparam int PFH_WRITE_HIGH_NS = 30;
	localparam int PFH_RANDOM_CYC = (PFH_RANDOM_ACCESS_NS + PFH_CLK_NS - 1) / PFH_CLK_NS;
	localparam int PFH_PAGE_CYC = (PFH_PAGE_ACCESS_NS + PFH_CLK_NS - 1) / PFH_CLK_NS;
	localparam int PFH_RESET_CYC = (PFH_RESET_PULSE_NS + PFH_CLK_NS - 1) / PFH_CLK_NS;
	localparam int PFH_WPULSE_CYC = (PFH_WRITE_PULSE_NS + PFH_CLK_NS - 1) / PFH_CLK_NS;
	localparam int PFH_WHIGH_CYC = (PFH_WRITE_HIGH_NS + PFH_CLK_NS - 1) / PFH_CLK_NS;
	localparam int PFH_CNT_W = 6;
	localparam logic [PFH_CNT_W-1:0] PFH_CNT_ZERO = 6'h00;
	// page is eight words: low three word-address bits pick the word
	localparam int PFH_PAGE_LSB = 3;
	localparam int PFH_BYTE_DATA_W = 8;
	typedef enum logic [2:0] {
		PFH_ST_RESET = 3'b000,
		PFH_ST_IDLE = 3'b001,
		PFH_ST_READ = 3'b010,
		PFH_ST_WRITE_LOW = 3'b011,
		PFH_ST_WRITE_HIGH = 3'b100
	} pfh_state_t;
endpackage

// ### pfh_timer.sv
// down-counter that flags when a loaded cycle count has expired
`timescale 1ns/100ps
module pfh_timer
	import pfh_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [PFH_CNT_W-1:0] count,
	output logic done
);
	logic [PFH_CNT_W-1:0] remain;
	assign done = (remain == PFH_CNT_ZERO);
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			remain <= PFH_CNT_ZERO;
		else if (load)
			remain <= count;
		else if (!done)
			remain <= remain - 6'h01;
	end
endmodule // pfh_timer

// ### pfh_host.sv
// host controller that drives an asynchronous parallel flash over its pins
// Notes on behaviour
// - reads: select and gate low, strobe high
// - commands: select and strobe low, gate high
// - short program mode uses two writes
// - high voltage only while accelerated programming
// - system reset drives flash reset
`timescale 1ns/100ps
module pfh_host
	import pfh_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [PFH_ADDR_W-1:0] req_addr,
	input wire logic [PFH_DATA_W-1:0] req_wdata,
	input wire logic byte_mode,
	input wire logic accel_enable,
	output logic req_ready,
	output logic rsp_valid,
	output logic [PFH_DATA_W-1:0] rsp_rdata,
	output logic [PFH_ADDR_W-1:0] flash_addr,
	output logic chip_enable_n,
	output logic output_gate_n,
	output logic write_strobe_n,
	output logic hw_clear_n,
	output logic width_select_n,
	output logic accel_high_voltage,
	input wire logic [PFH_DATA_W-1:0] flash_dq_in,
	output logic [PFH_DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe
);
	pfh_state_t state, next_state;
	logic page_valid;
	logic [PFH_ADDR_W-1:0] last_addr;
	logic timer_load;
	logic [PFH_CNT_W-1:0] timer_count;
	logic timer_done;
	logic req_take;
	logic same_page;
	function automatic logic [PFH_ADDR_W-PFH_PAGE_LSB-1:0] page_of(
		input logic [PFH_ADDR_W-1:0] a);
		page_of = a[PFH_ADDR_W-1:PFH_PAGE_LSB];
	endfunction
	// a request held through a reset is taken only once the flash reset pulse has ended
	assign req_take = (state == PFH_ST_IDLE) && req_valid;
	// in-page hit only while select stayed low since the last read
	assign same_page = page_valid && (page_of(req_addr) == page_of(last_addr));
	always_comb begin
		timer_load = 1'b0;
		timer_count = PFH_CNT_ZERO;
		next_state = state;
		case (state)
			PFH_ST_RESET: begin
				if (timer_done)
					next_state = PFH_ST_IDLE;
			end
			PFH_ST_IDLE: begin
				if (req_valid) begin
					timer_load = 1'b1;
					if (req_write) begin
						timer_count = PFH_CNT_W'(PFH_WPULSE_CYC);
						next_state = PFH_ST_WRITE_LOW;
					end else begin
						timer_count = same_page ? PFH_CNT_W'(PFH_PAGE_CYC)
							: PFH_CNT_W'(PFH_RANDOM_CYC);
						next_state = PFH_ST_READ;
					end
				end
			end
			PFH_ST_READ: begin
				if (timer_done)
					next_state = PFH_ST_IDLE;
			end
			PFH_ST_WRITE_LOW: begin
				if (timer_done) begin
					timer_load = 1'b1;
					timer_count = PFH_CNT_W'(PFH_WHIGH_CYC);
					next_state = PFH_ST_WRITE_HIGH;
				end
			end
			PFH_ST_WRITE_HIGH: begin
				if (timer_done)
					next_state = PFH_ST_IDLE;
			end
			default: next_state = PFH_ST_RESET;
		endcase
	end
	pfh_timer u_timer (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.load(timer_load),
		.count(timer_count),
		.done(timer_done)
	);
	// reset pulse length counted separately so the timer stays free for bus cycles
	logic [PFH_CNT_W-1:0] rst_cnt;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= PFH_ST_RESET;
			rst_cnt <= PFH_CNT_ZERO;
		end else if (state == PFH_ST_RESET) begin
			rst_cnt <= rst_cnt + 6'h01;
			if (rst_cnt == PFH_CNT_W'(PFH_RESET_CYC))
				state <= PFH_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end
	// flash reset held low for the least pulse after system reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			hw_clear_n <= 1'b0;
		else
			hw_clear_n <= (state != PFH_ST_RESET) || (rst_cnt == PFH_CNT_W'(PFH_RESET_CYC));
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			chip_enable_n <= 1'b1;
			output_gate_n <= 1'b1;
			write_strobe_n <= 1'b1;
			flash_addr <= '0;
			flash_dq_out <= '0;
			flash_dq_oe <= 1'b0;
			page_valid <= 1'b0;
			last_addr <= '0;
		end else if (req_take) begin
			flash_addr <= req_addr;
			chip_enable_n <= 1'b0;
			if (req_write) begin
				output_gate_n <= 1'b1;
				write_strobe_n <= 1'b0;
				// one bus write per request, so a short program is two requests
				flash_dq_out <= req_wdata;
				flash_dq_oe <= 1'b1;
				page_valid <= 1'b0;
			end else begin
				output_gate_n <= 1'b0;
				write_strobe_n <= 1'b1;
				flash_dq_oe <= 1'b0;
				last_addr <= req_addr;
				page_valid <= 1'b1;
			end
		end else if (state == PFH_ST_WRITE_LOW && timer_done) begin
			write_strobe_n <= 1'b1;
			chip_enable_n <= 1'b1;
		end else if (state == PFH_ST_WRITE_HIGH && timer_done) begin
			flash_dq_oe <= 1'b0;
		end else if (state == PFH_ST_IDLE && !req_valid) begin
			// deselect when idle; next read pays the full select time
			chip_enable_n <= 1'b1;
			output_gate_n <= 1'b1;
			page_valid <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			req_ready <= 1'b0;
			width_select_n <= 1'b1;
			accel_high_voltage <= 1'b0;
		end else begin
			rsp_valid <= (state == PFH_ST_READ) && timer_done;
			if ((state == PFH_ST_READ) && timer_done)
				// byte mode keeps only the low eight lines
				rsp_rdata <= byte_mode ? {8'h00, flash_dq_in[PFH_BYTE_DATA_W-1:0]}
					: flash_dq_in;
			req_ready <= (next_state == PFH_ST_IDLE) && (state != PFH_ST_RESET);
			width_select_n <= !byte_mode;
			// high voltage from the write take until one cycle after the write high time ends
			accel_high_voltage <= accel_enable && (state == PFH_ST_WRITE_LOW
				|| state == PFH_ST_WRITE_HIGH || (req_take && req_write));
		end
	end
	property p_read_pins;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == PFH_ST_READ) |-> (!chip_enable_n && !output_gate_n && write_strobe_n);
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("read pins wrong");
	property p_write_pins;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == PFH_ST_WRITE_LOW) |-> (!chip_enable_n && output_gate_n && !write_strobe_n);
	endproperty
	a_write_pins: assert property (p_write_pins) else $error("write pins wrong");
	property p_hv_only_write;
		@(posedge sys_clk) disable iff (sys_rst)
		accel_high_voltage |-> $past(accel_enable) && output_gate_n;
	endproperty
	a_hv_only_write: assert property (p_hv_only_write) else $error("high voltage misuse");
	property p_reset_pulse;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(hw_clear_n) |-> $past(!hw_clear_n, PFH_RESET_CYC);
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse short");
	// answer of an off-page read comes only after the full access count
	sequence s_full_wait;
		(!rsp_valid) [*6] ##1 rsp_valid;
	endsequence
	// answer of an in-page read comes after the short page count
	sequence s_page_wait;
		(!rsp_valid) [*2] ##1 rsp_valid;
	endsequence
	property p_full_read;
		@(posedge sys_clk) disable iff (sys_rst)
		(req_take && !req_write && !same_page) |-> ##1 s_full_wait;
	endproperty
	a_full_read: assert property (p_full_read) else $error("full read timing wrong");
	property p_page_read;
		@(posedge sys_clk) disable iff (sys_rst)
		(req_take && !req_write && same_page) |-> ##1 s_page_wait;
	endproperty
	a_page_read: assert property (p_page_read) else $error("page read timing wrong");
	property p_write_release;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == PFH_ST_WRITE_HIGH) |-> (chip_enable_n && write_strobe_n && output_gate_n);
	endproperty
	a_write_release: assert property (p_write_release) else $error("write not released");
	property p_reset_quiet;
		@(posedge sys_clk) disable iff (sys_rst)
		!hw_clear_n |-> (chip_enable_n && write_strobe_n && !flash_dq_oe);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("bus busy in reset");
endmodule // pfh_host

// ### pfh_flash_model.sv
// behavioural flash device answering the host controller pins
`timescale 1ns/100ps
module pfh_flash_model
	import pfh_pkg::*;
#(
	// both values are arbitrary
	parameter logic [PFH_DATA_W-1:0] ID_ENTRY_CMD = 16'h0066,
	parameter logic [PFH_DATA_W-1:0] ID_CODE = 16'h005A
)
(
	input wire logic sys_clk,
	input wire logic [PFH_ADDR_W-1:0] flash_addr,
	input wire logic chip_enable_n,
	input wire logic output_gate_n,
	input wire logic write_strobe_n,
	input wire logic hw_clear_n,
	input wire logic width_select_n,
	input wire logic accel_high_voltage,
	input wire logic [PFH_DATA_W-1:0] flash_dq_out,
	output logic [PFH_DATA_W-1:0] flash_dq_in,
	output logic [PFH_DATA_W-1:0] wr_data,
	output logic [PFH_ADDR_W-1:0] wr_addr,
	output logic wr_hv
);
	logic id_mode = 1'b0;
	logic ready = 1'b0;
	logic was_sel = 1'b0;
	logic [PFH_ADDR_W-1:0] held_addr = '0;
	realtime t_full = 0.0;
	realtime t_word = 0.0;
	logic [PFH_DATA_W-1:0] word;
	wire drive = !chip_enable_n && !output_gate_n && write_strobe_n && hw_clear_n;
	assign word = id_mode ? ID_CODE : flash_addr[15:0] ^ 16'hC3C3;
	// reselect or a new page restarts the full access, a new word only the page access
	always @(flash_addr or chip_enable_n) begin
		if (chip_enable_n || !was_sel
			|| flash_addr[PFH_ADDR_W-1:PFH_PAGE_LSB] != held_addr[PFH_ADDR_W-1:PFH_PAGE_LSB])
			t_full = $realtime;
		t_word = $realtime;
		held_addr = flash_addr;
		was_sel = !chip_enable_n;
	end
	// data stays valid while the inputs hold still, as in automatic sleep
	always @(negedge sys_clk)
		ready = ($realtime - t_full >= PFH_RANDOM_ACCESS_NS)
			&& ($realtime - t_word >= PFH_PAGE_ACCESS_NS);
	// floating or unsettled lines show the inverse so an early sample cannot match
	assign flash_dq_in = !(drive && ready) ? ~word
		: width_select_n ? word : {~word[15:8], word[7:0]};
	always @* begin
		if (!hw_clear_n)
			id_mode = 1'b0;
		else if (!write_strobe_n && !chip_enable_n && output_gate_n) begin
			id_mode = flash_dq_out == ID_ENTRY_CMD;
			wr_data = flash_dq_out;
			wr_addr = flash_addr;
			wr_hv = accel_high_voltage;
		end
	end
endmodule // pfh_flash_model

// ### testbench.sv
// self-checking testbench for the parallel flash host controller
`timescale 1ns/100ps
module testbench;
	import pfh_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [24:0] req_addr = 25'h0000000;
	logic [15:0] req_wdata = 16'h0000;
	logic byte_mode = 1'b0;
	logic accel_enable = 1'b0;
	logic req_ready, rsp_valid, ce_n, og_n, ws_n, hc_n, wsel_n, hv, oe, wr_hv;
	logic [15:0] rsp_rdata, dq_in, dq_out, wr_data;
	logic [24:0] flash_addr, wr_addr;
	int bad_count = 0;
	int checked = 0;
	// command and code values are arbitrary; any other write leaves id mode
	localparam logic [15:0] TB_ID_CMD = 16'h0066;
	localparam logic [15:0] TB_EXIT_CMD = 16'h0033;
	localparam logic [15:0] TB_ID_CODE = 16'h005A;
	always #12.5 sys_clk = ~sys_clk;
	pfh_host u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.byte_mode(byte_mode), .accel_enable(accel_enable), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .flash_addr(flash_addr),
		.chip_enable_n(ce_n), .output_gate_n(og_n), .write_strobe_n(ws_n),
		.hw_clear_n(hc_n), .width_select_n(wsel_n), .accel_high_voltage(hv),
		.flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(oe));
	pfh_flash_model #(.ID_ENTRY_CMD(TB_ID_CMD), .ID_CODE(TB_ID_CODE)) u_flash (
		.sys_clk(sys_clk), .flash_addr(flash_addr), .chip_enable_n(ce_n),
		.output_gate_n(og_n), .write_strobe_n(ws_n), .hw_clear_n(hc_n),
		.width_select_n(wsel_n), .accel_high_voltage(hv), .flash_dq_out(dq_out),
		.flash_dq_in(dq_in), .wr_data(wr_data), .wr_addr(wr_addr), .wr_hv(wr_hv));
	task give_verdict;
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wait_ready;
		for (int n = 0; n < 64 && req_ready !== 1'b1; n++)
			@(posedge sys_clk) #1;
		if (req_ready !== 1'b1) begin
			cmp(32'h0, 32'h1);
			give_verdict;
		end
	endtask
	task access(input logic w, input logic [24:0] a, input logic [15:0] d);
		wait_ready;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		@(posedge sys_clk) #1;
		req_valid = 1'b0;
	endtask
	task rd(input logic [24:0] a, input logic [15:0] e);
		access(1'b0, a, 16'h0000);
		for (int n = 0; n < 16 && rsp_valid !== 1'b1; n++)
			@(posedge sys_clk) #1;
		cmp({15'h0, rsp_valid, rsp_rdata}, {16'h0001, e});
		if (rsp_valid !== 1'b1)
			give_verdict;
	endtask
	task wr(input logic [24:0] a, input logic [15:0] d);
		access(1'b1, a, d);
		wait_ready;
		cmp({wr_data, wr_addr[15:0]}, {d, a[15:0]});
	endtask
	task t_array;
		rd(25'h0000123, 16'h0123 ^ 16'hC3C3);
		rd(25'h0000121, 16'h0121 ^ 16'hC3C3);
		rd(25'h0000047, 16'h0047 ^ 16'hC3C3);
		rd(25'h0000048, 16'h0048 ^ 16'hC3C3);
	endtask
	task t_id;
		wr(25'h0000555, TB_ID_CMD);
		rd(25'h0000001, TB_ID_CODE);
		wr(25'h0000000, TB_EXIT_CMD);
		rd(25'h0000010, 16'h0010 ^ 16'hC3C3);
	endtask
	task t_byte;
		byte_mode = 1'b1;
		rd(25'h0000000, 16'h00C3);
		cmp({31'h0, wsel_n}, 32'h0);
		byte_mode = 1'b0;
	endtask
	task t_accel;
		accel_enable = 1'b1;
		wr(25'h0000200, 16'h1234);
		cmp({31'h0, wr_hv}, 32'h1);
		rd(25'h0000200, 16'h0200 ^ 16'hC3C3);
		cmp({31'h0, hv}, 32'h0);
		accel_enable = 1'b0;
	endtask
	task t_burst;
		for (int i = 0; i < 16; i++)
			wr(25'h0000300 + 25'(i), 16'hA500 + 16'(i));
	endtask
	task t_reset;
		wr(25'h0000555, TB_ID_CMD);
		sys_rst = 1'b1;
		@(posedge sys_clk) #1;
		sys_rst = 1'b0;
		cmp({31'h0, hc_n}, 32'h0);
		rd(25'h0000001, 16'h0001 ^ 16'hC3C3);
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		t_array;
		t_id;
		t_byte;
		t_accel;
		t_burst;
		t_reset;
		give_verdict;
	end
endmodule // testbench
